// ===== src/spfs_top.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: the quarter-rate clock pad carries that clock after reset, enable bit zero, until set.
// RULE2: the sixth-rate clock pad drives that clock after reset with its enable bit zero.
// RULE3: the serial-two external clock pad serves that clock after reset, enable bit zero.
// RULE4: clock and serial-clock pads are muxed only by the software enable and direction bits.
// RULE5: a set enable bit hands the pad to general-purpose I/O instead of its peripheral.
// RULE6: on an enabled pad direction zero is input (driver off) and direction one is output.
// RULE7: pins 9 to 15 have no default and are usable as GPIO only with the PCI strap low.
// RULE8: after reset the serial-one/ATM shared pads belong to serial port one.
// RULE9: the ATM strap read as one at reset gives the serial-one shared pads to ATM.
// RULE10: after reset host/PCI pads belong to the host; halfword select is used in 16-bit mode.
// RULE11: the PCI strap read as one gives host pads and serial-two/EEPROM pads to PCI.
// RULE12: with a strap at zero every pad of that disabled peripheral alone is held high-Z.
// RULE13: a variant without PCI and ATM keeps only the clock and serial-clock GPIO muxing.
// RULE14: with ATM selected the serial-one standalone pads are held in high-Z.
// RULE15: software pad functions change any time; strap choices stay fixed, one owner a pad.
// RULE16: straps are latched after reset release and held until the next reset.
// RULE17: with the enable bit clear the pad follows its peripheral and direction is ignored.
module spfs_top
   import spfs_pkg::*;
#(
   parameter bit HAS_PCI_ATM = 1'b1
) (
   input  wire logic                    SYS_CLK_I,
   input  wire logic                    ARST_N_I,
   input  wire logic [7:0]              S_AWADDR_I,
   input  wire logic                    S_AWVALID_I,
   output logic                         S_AWREADY_O,
   input  wire logic [31:0]             S_WDATA_I,
   input  wire logic [3:0]              S_WSTRB_I,
   input  wire logic                    S_WVALID_I,
   output logic                         S_WREADY_O,
   output logic [1:0]                   S_BRESP_O,
   output logic                         S_BVALID_O,
   input  wire logic                    S_BREADY_I,
   input  wire logic [7:0]              S_ARADDR_I,
   input  wire logic                    S_ARVALID_I,
   output logic                         S_ARREADY_O,
   output logic [31:0]                  S_RDATA_O,
   output logic [1:0]                   S_RRESP_O,
   output logic                         S_RVALID_O,
   input  wire logic                    S_RREADY_I,
   input  wire logic                    ATM_STRAP_I,
   input  wire logic                    PCI_STRAP_I,
   input  wire logic                    HOST_16BIT_MODE_I,
   input  wire logic [GP_W-1:0]         GP_PAD_I,
   output logic [GP_W-1:0]              GP_PAD_O,
   output logic [GP_W-1:0]              GP_PAD_OE_N_O,
   input  wire logic                    QRT_CLK_OUT_I,
   input  wire logic                    SIXTH_CLK_OUT_I,
   output logic                         SP2_EXT_CLK_O,
   input  wire logic [PCI_GP_W-1:0]     PCI_GP_OUT_I,
   input  wire logic [PCI_GP_W-1:0]     PCI_GP_OE_N_I,
   input  wire logic [SP1_W-1:0]        SP1_OUT_I,
   input  wire logic [SP1_W-1:0]        SP1_OE_N_I,
   input  wire logic [SP1_W-1:0]        ATM_ADDR_OUT_I,
   input  wire logic [SP1_W-1:0]        ATM_ADDR_OE_N_I,
   output logic [SP1_W-1:0]             SP1_PAD_O,
   output logic [SP1_W-1:0]             SP1_PAD_OE_N_O,
   input  wire logic [SP1_SOLO_W-1:0]   SP1_SOLO_OUT_I,
   input  wire logic [SP1_SOLO_W-1:0]   SP1_SOLO_OE_N_I,
   output logic [SP1_SOLO_W-1:0]        SP1_SOLO_PAD_O,
   output logic [SP1_SOLO_W-1:0]        SP1_SOLO_PAD_OE_N_O,
   input  wire logic [ATM_SOLO_W-1:0]   ATM_SOLO_OUT_I,
   input  wire logic [ATM_SOLO_W-1:0]   ATM_SOLO_OE_N_I,
   output logic [ATM_SOLO_W-1:0]        ATM_SOLO_PAD_O,
   output logic [ATM_SOLO_W-1:0]        ATM_SOLO_PAD_OE_N_O,
   input  wire logic [HOST_W-1:0]       HOST_OUT_I,
   input  wire logic [HOST_W-1:0]       HOST_OE_N_I,
   input  wire logic [HOST_W-1:0]       PCI_OUT_I,
   input  wire logic [HOST_W-1:0]       PCI_OE_N_I,
   output logic [HOST_W-1:0]            HOST_PAD_O,
   output logic [HOST_W-1:0]            HOST_PAD_OE_N_O,
   input  wire logic [SP2_W-1:0]        SP2_OUT_I,
   input  wire logic [SP2_W-1:0]        SP2_OE_N_I,
   input  wire logic [SP2_W-1:0]        EEP_OUT_I,
   input  wire logic [SP2_W-1:0]        EEP_OE_N_I,
   output logic [SP2_W-1:0]             SP2_PAD_O,
   output logic [SP2_W-1:0]             SP2_PAD_OE_N_O,
   input  wire logic [PCI_SOLO_W-1:0]   PCI_SOLO_OUT_I,
   input  wire logic [PCI_SOLO_W-1:0]   PCI_SOLO_OE_N_I,
   output logic [PCI_SOLO_W-1:0]        PCI_SOLO_PAD_O,
   output logic [PCI_SOLO_W-1:0]        PCI_SOLO_PAD_OE_N_O,
   output logic                         ATM_SEL_O,
   output logic                         PCI_SEL_O
);

   ////////////////////////////////////////////////////////////////
   // synchronisers and strap latch

   logic [GP_W-1:0] gp_s1_q;
   logic [GP_W-1:0] gp_s2_q;
   logic [1:0]      strap_s1_q;
   logic [1:0]      strap_s2_q;
   logic [1:0]      settle_q;
   logic            strap_done_q;
   logic            atm_q;
   logic            pci_q;
   logic            latch_now;

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         gp_s1_q    <= '0;
         gp_s2_q    <= '0;
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
      end else begin
         gp_s1_q    <= GP_PAD_I;
         gp_s2_q    <= gp_s1_q;
         strap_s1_q <= {PCI_STRAP_I, ATM_STRAP_I};
         strap_s2_q <= strap_s1_q;
      end
   end

   // let straps clear the synchroniser
   assign latch_now = !strap_done_q && (settle_q == STRAP_SETTLE);

   // straps read zero until latched: defaults own pads
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         settle_q     <= 2'h0;
         strap_done_q <= 1'b0;
         atm_q        <= 1'b0; // RULE8
         pci_q        <= 1'b0; // RULE10
      end else if (latch_now) begin
         strap_done_q <= 1'b1; // RULE16
         atm_q        <= HAS_PCI_ATM & strap_s2_q[0]; // RULE9 RULE13
         pci_q        <= HAS_PCI_ATM & strap_s2_q[1]; // RULE11 RULE13
      end else if (!strap_done_q) begin
         settle_q     <= settle_q + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // axi4-lite slave

   logic [15:0] gp_en_q;
   logic [15:0] gp_dir_q;
   logic [15:0] gp_out_q;
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        wr_fire;
   logic        wr_en_hit;
   logic        wr_dir_hit;
   logic        wr_out_hit;
   logic        wr_ok;
   logic [15:0] wr_mask;
   logic [15:0] gp_wr_mask;
   logic [15:0] gp_en_d;
   logic [15:0] gp_dir_d;
   logic [15:0] gp_out_d;
   logic        rd_ok;
   logic [31:0] rd_word;

   // both halves captured, response not yet pending
   assign wr_fire    = !awready_q && !wready_q && !bvalid_q;
   assign wr_en_hit  = awaddr_q == OFS_GP_EN;
   assign wr_dir_hit = awaddr_q == OFS_GP_DIR;
   assign wr_out_hit = awaddr_q == OFS_GP_OUT;
   // read-only offsets accept writes silently
   assign wr_ok      = wr_en_hit || wr_dir_hit || wr_out_hit
                    || awaddr_q == OFS_GP_IN || awaddr_q == OFS_STRAP;
   // pins 9-15 exist as gpio only in the full variant
   assign gp_wr_mask = GP_SW_MASK | (HAS_PCI_ATM ? GP_PCI_MASK : 16'h0000); // RULE13
   assign wr_mask    = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & gp_wr_mask;
   assign gp_en_d    = (gp_en_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
   assign gp_dir_d   = (gp_dir_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
   assign gp_out_d   = (gp_out_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);

   assign rd_ok   = S_ARADDR_I == OFS_GP_EN || S_ARADDR_I == OFS_GP_DIR
                 || S_ARADDR_I == OFS_GP_OUT || S_ARADDR_I == OFS_GP_IN
                 || S_ARADDR_I == OFS_STRAP;
   assign rd_word = (S_ARADDR_I == OFS_GP_EN)  ? {16'h0000, gp_en_q}  :
                    (S_ARADDR_I == OFS_GP_DIR) ? {16'h0000, gp_dir_q} :
                    (S_ARADDR_I == OFS_GP_OUT) ? {16'h0000, gp_out_q} :
                    (S_ARADDR_I == OFS_GP_IN)  ? {16'h0000, gp_s2_q}  :
                    (S_ARADDR_I == OFS_STRAP)  ?
                       {29'h0, strap_done_q, pci_q, atm_q} : 32'h00000000;

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         if (S_AWVALID_I && awready_q) begin
            awaddr_q  <= S_AWADDR_I;
            awready_q <= 1'b0;
         end
         if (S_WVALID_I && wready_q) begin
            wdata_q  <= S_WDATA_I;
            wstrb_q  <= S_WSTRB_I;
            wready_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && S_BREADY_I) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // software may change pad functions at any time
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         gp_en_q  <= GP_EN_RST; // RULE1 RULE2 RULE3
         gp_dir_q <= GP_DIR_RST;
         gp_out_q <= GP_OUT_RST;
      end else if (wr_fire) begin
         if (wr_en_hit) gp_en_q <= gp_en_d; // RULE4 RULE15
         if (wr_dir_hit) gp_dir_q <= gp_dir_d; // RULE4
         if (wr_out_hit) gp_out_q <= gp_out_d;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= RESP_OKAY;
      end else if (S_ARVALID_I && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && S_RREADY_I) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // gpio-capable pads

   logic [GP_W-1:0] gp_avail;
   logic [GP_W-1:0] gp_own;
   logic [GP_W-1:0] dflt_out;
   logic [GP_W-1:0] dflt_oen;
   logic [GP_W-1:0] gp_pad_d;
   logic [GP_W-1:0] gp_oen_d;
   logic [PCI_GP_W-1:0] pci_gp_out;
   logic [PCI_GP_W-1:0] pci_gp_oen;

   // pins 9-15 are free for gpio only while pci is off
   assign gp_avail = GP_SW_MASK
                   | (GP_PCI_MASK & {GP_W{HAS_PCI_ATM && !pci_q}}); // RULE7
   // 9-15 float without pci: no default function
   assign pci_gp_out = pci_q ? PCI_GP_OUT_I : '0; // RULE11
   assign pci_gp_oen = pci_q ? PCI_GP_OE_N_I : '1; // RULE12
   assign dflt_out = {pci_gp_out, 1'b0, 5'h00, SIXTH_CLK_OUT_I, QRT_CLK_OUT_I, 1'b0};
   // serial-two clock is an input, so its driver stays off
   assign dflt_oen = {pci_gp_oen, 1'b1, 5'h1f, 1'b0, 1'b0, 1'b1}; // RULE1 RULE2 RULE3

   for (genvar i = 0; i < GP_W; i++) begin : g_gp
      assign gp_own[i]   = gp_en_q[i] && gp_avail[i]; // RULE5
      assign gp_pad_d[i] = gp_own[i] ? gp_out_q[i] : dflt_out[i]; // RULE17
      assign gp_oen_d[i] = gp_own[i] ? !gp_dir_q[i] : dflt_oen[i]; // RULE6 RULE17
   end

   ////////////////////////////////////////////////////////////////
   // strap-owned pad groups

   logic [SP1_W-1:0]      sp1_pad_d;
   logic [SP1_W-1:0]      sp1_oen_d;
   logic [HOST_W-1:0]     host_oen_m;
   logic [HOST_W-1:0]     host_pad_d;
   logic [HOST_W-1:0]     host_oen_d;
   logic [SP2_W-1:0]      sp2_pad_d;
   logic [SP2_W-1:0]      sp2_oen_d;

   assign sp1_pad_d = atm_q ? ATM_ADDR_OUT_I : SP1_OUT_I; // RULE8 RULE9
   assign sp1_oen_d = atm_q ? ATM_ADDR_OE_N_I : SP1_OE_N_I; // RULE9 RULE14

   // halfword select released outside 16-bit mode
   always_comb begin
      host_oen_m = HOST_OE_N_I;
      host_oen_m[HOST_HWSEL_IDX] = HOST_OE_N_I[HOST_HWSEL_IDX] | !HOST_16BIT_MODE_I; // RULE10
   end
   assign host_pad_d = pci_q ? PCI_OUT_I : HOST_OUT_I; // RULE10 RULE11
   assign host_oen_d = pci_q ? PCI_OE_N_I : host_oen_m; // RULE11
   assign sp2_pad_d  = pci_q ? EEP_OUT_I : SP2_OUT_I; // RULE11
   assign sp2_oen_d  = pci_q ? EEP_OE_N_I : SP2_OE_N_I; // RULE11

   ////////////////////////////////////////////////////////////////
   // output registers

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         GP_PAD_O            <= '0;
         GP_PAD_OE_N_O       <= '1;
         SP2_EXT_CLK_O       <= 1'b0;
         SP1_PAD_O           <= '0;
         SP1_PAD_OE_N_O      <= '1;
         SP1_SOLO_PAD_O      <= '0;
         SP1_SOLO_PAD_OE_N_O <= '1;
         ATM_SOLO_PAD_O      <= '0;
         ATM_SOLO_PAD_OE_N_O <= '1;
         HOST_PAD_O          <= '0;
         HOST_PAD_OE_N_O     <= '1;
         SP2_PAD_O           <= '0;
         SP2_PAD_OE_N_O      <= '1;
         PCI_SOLO_PAD_O      <= '0;
         PCI_SOLO_PAD_OE_N_O <= '1;
         ATM_SEL_O           <= 1'b0;
         PCI_SEL_O           <= 1'b0;
      end else begin
         GP_PAD_O            <= gp_pad_d;
         GP_PAD_OE_N_O       <= gp_oen_d;
         // peripheral sees a steady low while the pad is gpio
         SP2_EXT_CLK_O       <= gp_s2_q[GP_SP2CLK_BIT] && !gp_own[GP_SP2CLK_BIT]; // RULE3
         SP1_PAD_O           <= sp1_pad_d;
         SP1_PAD_OE_N_O      <= sp1_oen_d;
         SP1_SOLO_PAD_O      <= atm_q ? '0 : SP1_SOLO_OUT_I; // RULE14
         SP1_SOLO_PAD_OE_N_O <= atm_q ? '1 : SP1_SOLO_OE_N_I; // RULE14
         ATM_SOLO_PAD_O      <= atm_q ? ATM_SOLO_OUT_I : '0; // RULE12
         ATM_SOLO_PAD_OE_N_O <= atm_q ? ATM_SOLO_OE_N_I : '1; // RULE12
         HOST_PAD_O          <= host_pad_d;
         HOST_PAD_OE_N_O     <= host_oen_d;
         SP2_PAD_O           <= sp2_pad_d;
         SP2_PAD_OE_N_O      <= sp2_oen_d;
         PCI_SOLO_PAD_O      <= pci_q ? PCI_SOLO_OUT_I : '0; // RULE12
         PCI_SOLO_PAD_OE_N_O <= pci_q ? PCI_SOLO_OE_N_I : '1; // RULE12
         ATM_SEL_O           <= atm_q;
         PCI_SEL_O           <= pci_q;
      end
   end

   assign S_AWREADY_O = awready_q;
   assign S_WREADY_O  = wready_q;
   assign S_BVALID_O  = bvalid_q;
   assign S_BRESP_O   = bresp_q;
   assign S_ARREADY_O = arready_q;
   assign S_RVALID_O  = rvalid_q;
   assign S_RDATA_O   = rdata_q;
   assign S_RRESP_O   = rresp_q;

   ////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);

   qrt_clk_pad_a: assert property ( // RULE1
      ARST_N_I && !gp_en_q[GP_QRT_BIT] |=> GP_PAD_OE_N_O[GP_QRT_BIT] == 1'b0
                              && GP_PAD_O[GP_QRT_BIT] == $past(QRT_CLK_OUT_I))
      else $error("quarter-rate pad lost its clock");

   six_clk_pad_a: assert property ( // RULE2
      ARST_N_I && !gp_en_q[GP_SIX_BIT] |=> GP_PAD_O[GP_SIX_BIT] == $past(SIXTH_CLK_OUT_I))
      else $error("sixth-rate pad lost its clock");

   gp_dir_drive_a: assert property ( // RULE6
      gp_own[GP_SP2CLK_BIT] |=> GP_PAD_OE_N_O[GP_SP2CLK_BIT]
                                == !$past(gp_dir_q[GP_SP2CLK_BIT]))
      else $error("gpio direction not applied");

   pci_gp_block_a: assert property ( // RULE7
      pci_q |=> GP_PAD_OE_N_O[GP_W-1:GP_PCI_LO_BIT] == $past(PCI_GP_OE_N_I))
      else $error("gpio took a pci pin");

   strap_hold_a: assert property ( // RULE16
      strap_done_q |=> $stable(atm_q) && $stable(pci_q) && strap_done_q)
      else $error("strap choice changed after latch");

   strap_latch_time_a: assert property ( // RULE16
      $rose(strap_done_q) |-> settle_q == STRAP_SETTLE)
      else $error("straps latched at the wrong time");

   atm_solo_hiz_a: assert property ( // RULE12
      !atm_q |=> ATM_SOLO_PAD_OE_N_O == '1 ##0 ATM_SOLO_PAD_O == '0)
      else $error("disabled atm pads driven");

   sp1_solo_hiz_a: assert property ( // RULE14
      atm_q |=> SP1_SOLO_PAD_OE_N_O == '1)
      else $error("serial-one pads driven under atm");

   host_pci_own_a: assert property ( // RULE11
      pci_q |=> HOST_PAD_O == $past(PCI_OUT_I) && SP2_PAD_O == $past(EEP_OUT_I))
      else $error("pci strap did not take shared pads");

   sp1_atm_own_a: assert property ( // RULE9
      atm_q |=> SP1_PAD_OE_N_O == $past(ATM_ADDR_OE_N_I))
      else $error("atm strap did not take serial-one pads");

endmodule

// ===== src/spfs_pkg.sv
package spfs_pkg;
   // pad group widths
   localparam int          GP_W           = 16;
   localparam int          SP1_W          = 7;
   localparam int          SP1_SOLO_W     = 8;
   localparam int          ATM_SOLO_W     = 16;
   localparam int          HOST_W         = 42;
   localparam int          HOST_HWSEL_IDX = 40;
   localparam int          SP2_W          = 3;
   localparam int          PCI_SOLO_W     = 8;
   localparam int          PCI_GP_W       = 7;
   // gpio bit positions
   localparam int          GP_QRT_BIT     = 1;
   localparam int          GP_SIX_BIT     = 2;
   localparam int          GP_SP2CLK_BIT  = 8;
   localparam int          GP_PCI_LO_BIT  = 9;
   localparam logic [15:0] GP_SW_MASK     = 16'h0106;
   localparam logic [15:0] GP_PCI_MASK    = 16'hfe00;
   // reset values
   localparam logic [15:0] GP_EN_RST      = 16'h0000;
   localparam logic [15:0] GP_DIR_RST     = 16'h0000;
   localparam logic [15:0] GP_OUT_RST     = 16'h0000;
   // register byte offsets
   localparam logic [7:0]  OFS_GP_EN      = 8'h00;
   localparam logic [7:0]  OFS_GP_DIR     = 8'h04;
   localparam logic [7:0]  OFS_GP_OUT     = 8'h08;
   localparam logic [7:0]  OFS_GP_IN      = 8'h0c;
   localparam logic [7:0]  OFS_STRAP      = 8'h10;
   // strap status fields
   localparam int          STRAP_ATM_BIT  = 0;
   localparam int          STRAP_PCI_BIT  = 1;
   localparam int          STRAP_DONE_BIT = 2;
   localparam logic [1:0]  STRAP_SETTLE   = 2'h2;
   // axi responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ===== verification/tb_shared_pin_function_select.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
   $display("Error %0s expected %0h seen %0h", n, e, s); end end
module tb_shared_pin_function_select
   import spfs_pkg::*;
;
   logic                 SYS_CLK_I, ARST_N_I, S_AWVALID_I, S_WVALID_I, S_BREADY_I, S_ARVALID_I;
   logic                 S_RREADY_I, ATM_STRAP_I, PCI_STRAP_I, HOST_16BIT_MODE_I;
   logic                 QRT_CLK_OUT_I, SIXTH_CLK_OUT_I, SP2_EXT_CLK_O, ATM_SEL_O, PCI_SEL_O;
   logic                 S_AWREADY_O, S_WREADY_O, S_BVALID_O, S_ARREADY_O, S_RVALID_O;
   logic [7:0]           S_AWADDR_I, S_ARADDR_I;
   logic [31:0]          S_WDATA_I, S_RDATA_O;
   logic [3:0]           S_WSTRB_I;
   logic [1:0]           S_BRESP_O, S_RRESP_O;
   logic [15:0]          GP_PAD_I, GP_PAD_O, GP_PAD_OE_N_O, en_v, dir_v, out_v;
   logic [6:0]           PCI_GP_OUT_I, PCI_GP_OE_N_I, SP1_OUT_I, SP1_OE_N_I, SP1_PAD_O;
   logic [6:0]           ATM_ADDR_OUT_I, ATM_ADDR_OE_N_I, SP1_PAD_OE_N_O;
   logic [7:0]           SP1_SOLO_OUT_I, SP1_SOLO_OE_N_I, SP1_SOLO_PAD_O, SP1_SOLO_PAD_OE_N_O;
   logic [7:0]           PCI_SOLO_OUT_I, PCI_SOLO_OE_N_I, PCI_SOLO_PAD_O, PCI_SOLO_PAD_OE_N_O;
   logic [15:0]          ATM_SOLO_OUT_I, ATM_SOLO_OE_N_I, ATM_SOLO_PAD_O, ATM_SOLO_PAD_OE_N_O;
   logic [41:0]          HOST_OUT_I, HOST_OE_N_I, PCI_OUT_I, PCI_OE_N_I, HOST_PAD_O, HOST_PAD_OE_N_O;
   logic [2:0]           SP2_OUT_I, SP2_OE_N_I, EEP_OUT_I, EEP_OE_N_I, SP2_PAD_O, SP2_PAD_OE_N_O;
   logic [31:0]          seed = 32'd97487;
   logic [127:0]         eq[$];
   logic [127:0]         obs;
   string                nq[$];
   event                 obs_ev;
   int                   err_count = 0;
   int                   samples_checked = 0;

   spfs_top #(.HAS_PCI_ATM(1'b1)) DUT (
      .SYS_CLK_I, .ARST_N_I, .S_AWADDR_I, .S_AWVALID_I, .S_AWREADY_O, .S_WDATA_I, .S_WSTRB_I,
      .S_WVALID_I, .S_WREADY_O, .S_BRESP_O, .S_BVALID_O, .S_BREADY_I, .S_ARADDR_I,
      .S_ARVALID_I, .S_ARREADY_O, .S_RDATA_O, .S_RRESP_O, .S_RVALID_O, .S_RREADY_I,
      .ATM_STRAP_I, .PCI_STRAP_I, .HOST_16BIT_MODE_I, .GP_PAD_I, .GP_PAD_O, .GP_PAD_OE_N_O,
      .QRT_CLK_OUT_I, .SIXTH_CLK_OUT_I, .SP2_EXT_CLK_O, .PCI_GP_OUT_I, .PCI_GP_OE_N_I,
      .SP1_OUT_I, .SP1_OE_N_I, .ATM_ADDR_OUT_I, .ATM_ADDR_OE_N_I, .SP1_PAD_O, .SP1_PAD_OE_N_O,
      .SP1_SOLO_OUT_I, .SP1_SOLO_OE_N_I, .SP1_SOLO_PAD_O, .SP1_SOLO_PAD_OE_N_O,
      .ATM_SOLO_OUT_I, .ATM_SOLO_OE_N_I, .ATM_SOLO_PAD_O, .ATM_SOLO_PAD_OE_N_O,
      .HOST_OUT_I, .HOST_OE_N_I, .PCI_OUT_I, .PCI_OE_N_I, .HOST_PAD_O, .HOST_PAD_OE_N_O,
      .SP2_OUT_I, .SP2_OE_N_I, .EEP_OUT_I, .EEP_OE_N_I, .SP2_PAD_O, .SP2_PAD_OE_N_O,
      .PCI_SOLO_OUT_I, .PCI_SOLO_OE_N_I, .PCI_SOLO_PAD_O, .PCI_SOLO_PAD_OE_N_O,
      .ATM_SEL_O, .PCI_SEL_O
   );

////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lf(input logic [31:0] s);
      lf = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction

   task test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic take(input logic [127:0] s);
      string        n;
      logic [127:0] e;
      if (eq.size() == 0) begin
         err_count++;
         $display("Error unexpected result seen %0h", s);
      end else begin
         n = nq.pop_front();
         e = eq.pop_front();
         `CHK(n, e, s)
      end
   endtask

   // bus answers taken at their handshake edge
   always @(posedge SYS_CLK_I) begin
      if (S_RVALID_O && S_RREADY_I) take({94'h0, S_RRESP_O, S_RDATA_O});
      if (S_BVALID_O && S_BREADY_I) take({94'h0, S_BRESP_O, 32'h0});
   end
   always @(obs_ev) take(obs);

   task pchk(input string n, input logic [127:0] e, input logic [127:0] s);
      nq.push_back(n);
      eq.push_back(e);
      obs = s;
      -> obs_ev;
      #1;
   endtask

////////////////////////////////////////////////////////////////////////////////
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      nq.push_back("bresp");
      eq.push_back({94'h0, r, 32'h0});
      @(posedge SYS_CLK_I);
      {S_AWADDR_I, S_WDATA_I, S_WSTRB_I} <= {a, d, 4'h3};
      {S_AWVALID_I, S_WVALID_I, S_BREADY_I} <= 3'h7;
      do begin
         @(posedge SYS_CLK_I);
         if (S_AWREADY_O) S_AWVALID_I <= 1'b0;
         if (S_WREADY_O) S_WVALID_I <= 1'b0;
      end while (!S_BVALID_O);
      S_BREADY_I <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d, input string n);
      nq.push_back(n);
      eq.push_back({94'h0, r, d});
      @(posedge SYS_CLK_I);
      {S_ARADDR_I, S_ARVALID_I, S_RREADY_I} <= {a, 2'h3};
      do begin
         @(posedge SYS_CLK_I);
         if (S_ARREADY_O) S_ARVALID_I <= 1'b0;
      end while (!S_RVALID_O);
      S_RREADY_I <= 1'b0;
   endtask

   task rst(input logic a, input logic p, input logic h);
      @(posedge SYS_CLK_I);
      ARST_N_I <= 1'b0;
      {ATM_STRAP_I, PCI_STRAP_I, HOST_16BIT_MODE_I} <= {a, p, h};
      {en_v, dir_v, out_v} = '0;
      repeat (2) @(posedge SYS_CLK_I);
      ARST_N_I <= 1'b1;
      repeat (8) @(posedge SYS_CLK_I);
   endtask

   // 4 edges cover the pad-8 synchroniser
   task rnd;
      logic [319:0] p;
      for (int i = 0; i < 10; i++) begin
         repeat (32) seed = lf(seed);
         p[i*32 +: 32] = seed;
      end
      @(posedge SYS_CLK_I);
      {HOST_OUT_I, HOST_OE_N_I, PCI_OUT_I, PCI_OE_N_I} <= p[167:0];
      {SP1_OUT_I, SP1_OE_N_I, ATM_ADDR_OUT_I, ATM_ADDR_OE_N_I} <= p[195:168];
      {ATM_SOLO_OUT_I, ATM_SOLO_OE_N_I} <= p[227:196];
      {SP1_SOLO_OUT_I, SP1_SOLO_OE_N_I, PCI_SOLO_OUT_I, PCI_SOLO_OE_N_I} <= p[259:228];
      {SP2_OUT_I, SP2_OE_N_I, EEP_OUT_I, EEP_OE_N_I} <= p[271:260];
      {PCI_GP_OUT_I, PCI_GP_OE_N_I, QRT_CLK_OUT_I, SIXTH_CLK_OUT_I} <= p[287:272];
      GP_PAD_I <= p[303:288];
      repeat (4) @(posedge SYS_CLK_I);
      #1;
   endtask

   // expected pads from the bench's copy of the registers
   task pads(input logic a, input logic p);
      logic [15:0] es, eo, dz, dq;
      logic [41:0] hm;
      es = en_v & (GP_SW_MASK | (p ? 16'h0 : GP_PCI_MASK));
      dz = {p ? PCI_GP_OE_N_I : 7'h7f, 9'h1f9};
      dq = {p ? PCI_GP_OUT_I : 7'h0, 6'h0, SIXTH_CLK_OUT_I, QRT_CLK_OUT_I, 1'b0};
      eo = (es & ~dir_v | ~es & dz) & 16'hff06;
      hm = HOST_16BIT_MODE_I ? 42'h0 : 42'h1 << HOST_HWSEL_IDX;
      pchk("gp_oe", eo, GP_PAD_OE_N_O & 16'hff06);
      pchk("gp_out", (es & dir_v & out_v | ~es & dq) & ~eo, GP_PAD_O & ~eo & 16'hff06);
      pchk("sp2clk", en_v[8] ? 1'b0 : GP_PAD_I[8], SP2_EXT_CLK_O);
      pchk("sp1", a ? {ATM_ADDR_OUT_I, ATM_ADDR_OE_N_I} : {SP1_OUT_I, SP1_OE_N_I},
           {SP1_PAD_O, SP1_PAD_OE_N_O});
      pchk("sp1solo", a ? {8'h0, 8'hff} : {SP1_SOLO_OUT_I, SP1_SOLO_OE_N_I},
           {SP1_SOLO_PAD_O, SP1_SOLO_PAD_OE_N_O});
      pchk("atmsolo", a ? {ATM_SOLO_OUT_I, ATM_SOLO_OE_N_I} : {16'h0, 16'hffff},
           {ATM_SOLO_PAD_O, ATM_SOLO_PAD_OE_N_O});
      pchk("pcisolo", p ? {PCI_SOLO_OUT_I, PCI_SOLO_OE_N_I} : {8'h0, 8'hff},
           {PCI_SOLO_PAD_O, PCI_SOLO_PAD_OE_N_O});
      pchk("host", p ? {PCI_OUT_I, PCI_OE_N_I} : {HOST_OUT_I & ~hm, HOST_OE_N_I | hm},
           {HOST_PAD_O & ~hm, HOST_PAD_OE_N_O});
      pchk("sp2", p ? {EEP_OUT_I, EEP_OE_N_I} : {SP2_OUT_I, SP2_OE_N_I},
           {SP2_PAD_O, SP2_PAD_OE_N_O});
      pchk("sel", {a, p}, {ATM_SEL_O, PCI_SEL_O});
   endtask

////////////////////////////////////////////////////////////////////////////////
   initial begin
      SYS_CLK_I = 1'b0;
      forever #5 SYS_CLK_I = ~SYS_CLK_I;
   end

   initial begin
      repeat (5000) @(posedge SYS_CLK_I);
      err_count++;
      test_done;
   end

   initial begin
      {ARST_N_I, S_AWVALID_I, S_WVALID_I, S_BREADY_I, S_ARVALID_I, S_RREADY_I, ATM_STRAP_I,
       PCI_STRAP_I, HOST_16BIT_MODE_I, QRT_CLK_OUT_I, SIXTH_CLK_OUT_I, S_AWADDR_I, S_ARADDR_I,
       S_WDATA_I, S_WSTRB_I, GP_PAD_I, PCI_GP_OUT_I, PCI_GP_OE_N_I, SP1_OUT_I, SP1_OE_N_I,
       ATM_ADDR_OUT_I, ATM_ADDR_OE_N_I, SP1_SOLO_OUT_I, SP1_SOLO_OE_N_I, PCI_SOLO_OUT_I,
       PCI_SOLO_OE_N_I, ATM_SOLO_OUT_I, ATM_SOLO_OE_N_I, HOST_OUT_I, HOST_OE_N_I, PCI_OUT_I,
       PCI_OE_N_I, SP2_OUT_I, SP2_OE_N_I, EEP_OUT_I, EEP_OE_N_I} = '0;
      rst(1'b0, 1'b0, 1'b0);
      rnd;
      pads(1'b0, 1'b0);
      rd(OFS_GP_EN, RESP_OKAY, {16'h0, GP_EN_RST}, "en_rst");
      rd(OFS_GP_DIR, RESP_OKAY, {16'h0, GP_DIR_RST}, "dir_rst");
      rd(OFS_STRAP, RESP_OKAY, 32'h1 << STRAP_DONE_BIT, "strap");
      $display("test defaults finished");
      // two direction sets, then enable cleared
      for (int k = 0; k < 3; k++) begin
         repeat (16) seed = lf(seed);
         out_v = seed[15:0];
         dir_v = (k == 1) ? 16'h0f02 : 16'hf104;
         en_v = (k == 2) ? 16'h0000 : 16'hff06;
         wr(OFS_GP_DIR, {16'h0, dir_v}, RESP_OKAY);
         wr(OFS_GP_OUT, {16'h0, out_v}, RESP_OKAY);
         wr(OFS_GP_EN, (k == 2) ? 32'h0 : 32'hffffffff, RESP_OKAY);
         HOST_16BIT_MODE_I <= k[0];
         rnd;
         pads(1'b0, 1'b0);
         rd(OFS_GP_EN, RESP_OKAY, {16'h0, en_v}, "en_mask");
         rd(OFS_GP_IN, RESP_OKAY, {16'h0, GP_PAD_I}, "pad_in");
      end
      $display("test gpio finished");
      wr(8'h20, 32'h5, RESP_SLVERR);
      rd(8'h20, RESP_SLVERR, 32'h0, "unmapped");
      wr(OFS_STRAP, 32'hffffffff, RESP_OKAY);
      rd(OFS_STRAP, RESP_OKAY, 32'h1 << STRAP_DONE_BIT, "strap_ro");
      $display("test access finished");
      rst(1'b1, 1'b1, 1'b1);
      rnd;
      pads(1'b1, 1'b1);
      // straps dropping must not move any owner
      @(posedge SYS_CLK_I);
      {ATM_STRAP_I, PCI_STRAP_I} <= 2'h0;
      en_v = 16'hff06;
      dir_v = 16'hffff;
      wr(OFS_GP_DIR, 32'hffff, RESP_OKAY);
      wr(OFS_GP_EN, 32'hffff, RESP_OKAY);
      rnd;
      pads(1'b1, 1'b1);
      rd(OFS_STRAP, RESP_OKAY, 32'h7, "strap_hold");
      $display("test straps finished");
      test_done;
   end
endmodule
